/* inc/lvirc_consts.svh */
// constants of the supply detector interrupt and reset control block
//
// Notes on behaviour
// (R01) option bits 1,0 select combined mode
// (R02) hold reset until supply above high
// (R03) interrupt when supply drops below high
// (R04) reset when supply then drops below low
// (R05) no second interrupt without low drop
// (R06) any reset sets interrupt mask to one
// (R07) software waits 400us or 5 slow clocks
// (R08) software then clears detector mode bit
// (R09) write enable set masks reset and interrupt
// (R10) detector lag at most 300 us
// (R11) detector off: external reset low 10us
// (R12) power-on with detector off: pin low
// (R13) combined mode starts with level register zero
// (R14) combined mode starts with write enable zero
// (R15) comparator outputs synchronised before use
// (R16) cause flag set on detector reset release
`ifndef LVIRC_CONSTS_SVH
`define LVIRC_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LVIRC_CLK_MHZ        10
`define LVIRC_DET_DELAY_US   300
`define LVIRC_DET_DELAY_CYC  (`LVIRC_DET_DELAY_US * `LVIRC_CLK_MHZ)
`define LVIRC_PIPE_CYC       4
`define LVIRC_FLT_COUNT      (`LVIRC_DET_DELAY_CYC - `LVIRC_PIPE_CYC)

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define LVIRC_OFS_CTRL       32'h0000_0000
`define LVIRC_OFS_LEVEL      32'h0000_0004
`define LVIRC_OFS_MASK       32'h0000_0008
`define LVIRC_OFS_STATUS     32'h0000_000C
`define LVIRC_WEN_BIT        7
`define LVIRC_MODE_BIT       7
`define LVIRC_LVSEL_BIT      0
`define LVIRC_MASK_BIT       0
`define LVIRC_CAUSE_BIT      0
`define LVIRC_HIGH_BIT       1
`define LVIRC_LOW_BIT        2
`define LVIRC_WARNED_BIT     3
`define LVIRC_RST_BIT        4

// ----------------------------------------------------------------
// reset values and mode code
// ----------------------------------------------------------------
`define LVIRC_LEVEL_RST      8'h00
`define LVIRC_WEN_RST        1'b0
`define LVIRC_MASK_RST       1'b1
`define LVIRC_MODE_IRQ_RST   2'h2

`endif

/* inc/lvirc_pkg.sv */
// types of the supply detector interrupt and reset control block
package lvirc_pkg;

  typedef enum logic [1:0] {
    LVIRC_ST_HOLD,
    LVIRC_ST_ARMED,
    LVIRC_ST_WARNED
  } lvirc_state_e;

  typedef struct packed {
    lvirc_state_e st;
    logic         wen;
    logic         mode_bit;
    logic         lvsel;
    logic         mask;
    logic         cause;
    logic         irq;
    logic         det_rst;
    logic         wr_pend;
    logic [1:0]   wr_idx;
    logic [31:0]  hrdata;
  } lvirc_top_s;

endpackage

/* design/lvirc_sync.sv */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module lvirc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } lvirc_sync_s;

  lvirc_sync_s cur_ff;
  lvirc_sync_s nxt_cur;

  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.meta = din;
    nxt_cur.sync = cur_ff.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign dout = cur_ff.sync;
endmodule

/* design/lvirc_filter.sv */
// stability filter: output follows input after COUNT steady cycles
`timescale 1ns/1ps
module lvirc_filter #(
  parameter int unsigned COUNT = 2996,
  parameter int unsigned CW    = 12
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } lvirc_flt_s;

  lvirc_flt_s cur_ff;
  lvirc_flt_s nxt_cur;

  // a glitch shorter than COUNT cycles restarts the count, so chatter near
  // the threshold never reaches the sequencer
  always_comb begin
    nxt_cur = cur_ff;
    if (din == cur_ff.out) begin
      nxt_cur.cnt = '0;
    end else if (cur_ff.cnt == CW'(COUNT - 1)) begin
      nxt_cur.out = din;
      nxt_cur.cnt = '0;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 1'b1;
    end
  end

  // out resets low: supply taken as below threshold until proven otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign dout = cur_ff.out;
endmodule

/* design/lvirc_top.sv */
// supply detector interrupt and reset sequencer with ahb-lite registers
`timescale 1ns/1ps
`include "lvirc_consts.svh"
module lvirc_top
  import lvirc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        opt_mode_sel_hi,
  input  wire logic        opt_mode_sel_lo,
  input  wire logic        cmp_above_high,
  input  wire logic        cmp_above_low,
  output logic             supply_detector_rst,
  output logic             supply_warn_irq
);
  localparam int unsigned FLT_COUNT = `LVIRC_FLT_COUNT; // R10
  localparam int unsigned FLT_CW    = 12;
  localparam logic [7:0]  LEVEL_RST = `LVIRC_LEVEL_RST;

  // ----------------------------------------------------------------
  // input synchronisation and filtering
  // ----------------------------------------------------------------
  logic [1:0] opt_s;
  logic [1:0] cmp_s;
  logic       high_f;
  logic       low_f;
  logic       mode_on;

  lvirc_sync #(
    .WIDTH (2)
  ) u_opt_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({opt_mode_sel_hi, opt_mode_sel_lo}),
    .dout    (opt_s)
  );

  // comparators are asynchronous analog levels
  lvirc_sync #(
    .WIDTH (2)
  ) u_cmp_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({cmp_above_high, cmp_above_low}), // R15
    .dout    (cmp_s)
  );

  lvirc_filter #(
    .COUNT (FLT_COUNT),
    .CW    (FLT_CW)
  ) u_high_flt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (cmp_s[1]),
    .dout    (high_f)
  );

  lvirc_filter #(
    .COUNT (FLT_COUNT),
    .CW    (FLT_CW)
  ) u_low_flt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (cmp_s[0]),
    .dout    (low_f)
  );

  assign mode_on = (opt_s == `LVIRC_MODE_IRQ_RST); // R01

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  lvirc_top_s cur_ff;
  lvirc_top_s nxt_cur;
  logic [2:0] dec;
  logic       addr_ph;

  // returns {hit, index}; anything outside the four aligned words misses
  function automatic logic [2:0] lvirc_decode(input logic [31:0] a);
    logic [2:0] r;
    r = {1'b0, a[3:2]};
    if ((a[31:4] == 28'h000_0000) && (a[1:0] == 2'h0)) begin
      r[2] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [31:0] lvirc_read(input logic [1:0] idx,
                                             input lvirc_top_s s,
                                             input logic hi,
                                             input logic lo);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      2'h0: begin
        r[`LVIRC_WEN_BIT] = s.wen;
      end
      2'h1: begin
        r[`LVIRC_MODE_BIT]  = s.mode_bit;
        r[`LVIRC_LVSEL_BIT] = s.lvsel;
      end
      2'h2: begin
        r[`LVIRC_MASK_BIT] = s.mask;
      end
      2'h3: begin
        r[`LVIRC_CAUSE_BIT]  = s.cause;
        r[`LVIRC_HIGH_BIT]   = hi;
        r[`LVIRC_LOW_BIT]    = lo;
        r[`LVIRC_WARNED_BIT] = (s.st == LVIRC_ST_WARNED);
        r[`LVIRC_RST_BIT]    = s.det_rst;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  assign dec     = lvirc_decode(haddr);
  assign addr_ph = hsel & hready & htrans[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur     = cur_ff;
    nxt_cur.irq = 1'b0;

    // data phase of a write taken one cycle earlier
    if (cur_ff.wr_pend) begin
      case (cur_ff.wr_idx)
        2'h0: begin
          nxt_cur.wen = hwdata[`LVIRC_WEN_BIT];
        end
        2'h1: begin
          // level register is locked unless write enable is set
          if (cur_ff.wen) begin // R14
            nxt_cur.mode_bit = hwdata[`LVIRC_MODE_BIT];
            nxt_cur.lvsel    = hwdata[`LVIRC_LVSEL_BIT];
          end
        end
        2'h2: begin
          nxt_cur.mask = hwdata[`LVIRC_MASK_BIT];
        end
        2'h3: begin
          if (hwdata[`LVIRC_CAUSE_BIT]) begin
            nxt_cur.cause = 1'b0;
          end
        end
        default: begin
          nxt_cur.wen = cur_ff.wen;
        end
      endcase
    end

    // address phase; read data is fetched now so it is ready with no wait
    nxt_cur.wr_pend = addr_ph & hwrite & dec[2];
    nxt_cur.wr_idx  = dec[1:0];
    if (addr_ph && !hwrite) begin
      if (dec[2]) begin
        nxt_cur.hrdata = lvirc_read(dec[1:0], cur_ff, high_f, low_f);
      end else begin
        nxt_cur.hrdata = 32'h0000_0000;
      end
    end

    // sequencer runs after the bus so its flag set beats a same-cycle clear
    if (mode_on) begin
      case (cur_ff.st)
        LVIRC_ST_HOLD: begin
          if (high_f) begin // R02
            nxt_cur.st    = LVIRC_ST_ARMED;
            nxt_cur.cause = 1'b1; // R16
          end
        end
        LVIRC_ST_ARMED: begin
          if (!cur_ff.wen) begin // R09
            if (!low_f) begin
              nxt_cur.st = LVIRC_ST_HOLD;
            end else if (!high_f) begin
              nxt_cur.st  = LVIRC_ST_WARNED; // R03
              nxt_cur.irq = ~cur_ff.mask;
            end
          end
        end
        LVIRC_ST_WARNED: begin
          // climbing back over high keeps this state, so no second warning
          if (!cur_ff.wen && !low_f) begin // R04 R05 R09
            nxt_cur.st = LVIRC_ST_HOLD;
          end
        end
        default: begin
          nxt_cur.st = LVIRC_ST_HOLD;
        end
      endcase
    end else begin
      nxt_cur.st = LVIRC_ST_HOLD;
    end

    nxt_cur.det_rst = mode_on && (nxt_cur.st == LVIRC_ST_HOLD);
    if (nxt_cur.det_rst) begin
      nxt_cur.mask     = `LVIRC_MASK_RST; // R06
      nxt_cur.wen      = `LVIRC_WEN_RST; // R14
      nxt_cur.mode_bit = LEVEL_RST[`LVIRC_MODE_BIT]; // R13
      nxt_cur.lvsel    = LEVEL_RST[`LVIRC_LVSEL_BIT]; // R13
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff          <= '0;
      cur_ff.st       <= LVIRC_ST_HOLD;
      cur_ff.mask     <= `LVIRC_MASK_RST; // R06
      cur_ff.wen      <= `LVIRC_WEN_RST;
      cur_ff.mode_bit <= LEVEL_RST[`LVIRC_MODE_BIT];
      cur_ff.lvsel    <= LEVEL_RST[`LVIRC_LVSEL_BIT];
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = cur_ff.hrdata;
  assign supply_detector_rst = cur_ff.det_rst;
  assign supply_warn_irq     = cur_ff.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [12:0] lag_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lag_cnt <= 13'h0000;
    end else if (cmp_s[1] != high_f) begin
      lag_cnt <= lag_cnt + 13'h0001;
    end else begin
      lag_cnt <= 13'h0000;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_release;
    cur_ff.det_rst ##1 !cur_ff.det_rst;
  endsequence

  sequence s_warned_steady;
    (cur_ff.st == LVIRC_ST_WARNED) && low_f && mode_on;
  endsequence

  mode_gate_a: assert property ( // R01
    !mode_on |=> !supply_detector_rst && !supply_warn_irq)
    else $error("detector active outside combined mode");

  hold_release_a: assert property ( // R02
    (cur_ff.st == LVIRC_ST_HOLD) && mode_on && high_f
      |=> (cur_ff.st == LVIRC_ST_ARMED) && !supply_detector_rst)
    else $error("reset not released above high threshold");

  warn_irq_a: assert property ( // R03
    (cur_ff.st == LVIRC_ST_ARMED) && mode_on && !cur_ff.wen && !high_f && low_f
      && !cur_ff.mask |=> supply_warn_irq ##1 !supply_warn_irq)
    else $error("warning interrupt missing or not a pulse");

  low_reset_a: assert property ( // R04
    (cur_ff.st == LVIRC_ST_WARNED) && mode_on && !cur_ff.wen && !low_f
      |=> supply_detector_rst)
    else $error("reset missing below low threshold");

  no_rewarn_a: assert property ( // R05
    s_warned_steady |=> !supply_warn_irq && (cur_ff.st == LVIRC_ST_WARNED))
    else $error("second warning without low drop");

  mask_set_a: assert property ( // R06
    supply_detector_rst |-> cur_ff.mask)
    else $error("mask clear while detector reset held");

  wen_block_a: assert property ( // R09
    cur_ff.wen && (cur_ff.st != LVIRC_ST_HOLD) && mode_on
      |=> !supply_warn_irq && !supply_detector_rst)
    else $error("event raised while write enable set");

  lag_bound_a: assert property ( // R10
    lag_cnt <= 13'(FLT_COUNT))
    else $error("comparator lag beyond bound");

  init_level_a: assert property ( // R13 R14
    s_release |-> !cur_ff.mode_bit && !cur_ff.lvsel && !cur_ff.wen)
    else $error("level register not initialised at release");

  cause_set_a: assert property ( // R16
    s_release |-> cur_ff.cause)
    else $error("cause flag not set at release");

endmodule

/* testbench/lvirc_supply_model.sv */
// supply comparator model driven by a commanded supply level
`timescale 1ns/1ps
module lvirc_supply_model (
  input  wire logic [1:0] lvl,
  output logic            cmp_above_high,
  output logic            cmp_above_low
);
  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  // lvl: 0 below low, 1 between thresholds, 2 above high
  // the offset keeps changes unrelated to the clock edge; outputs start low
  // whatever the bench's first level, so the comparators are never unknown
  initial begin
    cmp_above_high = 1'b0;
    cmp_above_low  = 1'b0;
    forever begin
      @(lvl);
      #37;
      cmp_above_high = (lvl == 2'd2);
      cmp_above_low  = (lvl != 2'd0);
    end
  end
endmodule

/* testbench/test_low_voltage_int_reset_ctrl.sv */
// self-checking bench of the supply detector interrupt and reset block
`timescale 1ns/1ps
`include "lvirc_consts.svh"
module test_low_voltage_int_reset_ctrl;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        opt_hi;
  logic        opt_lo;
  logic        cmp_hi;
  logic        cmp_lo;
  logic        supply_detector_rst;
  logic        supply_warn_irq;
  logic [1:0]  lvl;
  logic [31:0] d;
  int          fails;
  int          n_compared;
  int          irq_cnt = 0;
  int          n;
  logic        ok;

  lvirc_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .opt_mode_sel_hi(opt_hi), .opt_mode_sel_lo(opt_lo),
    .cmp_above_high(cmp_hi), .cmp_above_low(cmp_lo),
    .supply_detector_rst(supply_detector_rst), .supply_warn_irq(supply_warn_irq)
  );

  lvirc_supply_model supply (
    .lvl(lvl), .cmp_above_high(cmp_hi), .cmp_above_low(cmp_lo)
  );

  // ----------------------------------------------------------------
  // clock, pulse counter and watchdog
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // a level instead of a pulse shows up as a count above one
  always @(posedge hclk) begin
    if (supply_warn_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  initial begin
    #(60000 * 100);
    fails++;
    summarize();
  end

  // ----------------------------------------------------------------
  // bus tasks and compare
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    xfer(a, 1'b1, wd);
  endtask

  task automatic rd(input logic [31:0] a);
    xfer(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait; lag from a supply change must stay within 300 us
  task automatic wait_rst(input logic v);
    ok = 1'b0;
    for (int i = 0; i < `LVIRC_DET_DELAY_CYC + 1 && !ok; i++) begin
      @(posedge hclk);
      #1;
      if (supply_detector_rst === v) ok = 1'b1;
    end
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    opt_hi  = 1'b1;
    opt_lo  = 1'b0;
    lvl     = 2'd0;
    fails   = 0;
    n_compared = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(supply_detector_rst, 1);
    rd(`LVIRC_OFS_CTRL);   chk(d, 32'h0000_0000);
    rd(`LVIRC_OFS_LEVEL);  chk(d, 32'h0000_0000);
    rd(`LVIRC_OFS_MASK);   chk(d, 32'h0000_0001);
    rd(32'h0000_0010);     chk(d, 32'h0000_0000);
    chk(32'({hreadyout, hresp}), 32'h0000_0002);
    $display("test reset_values done");

    lvl <= 2'd2;
    wait_rst(1'b0); chk(ok, 1);
    rd(`LVIRC_OFS_STATUS); chk(d & 32'h0000_0001, 32'h0000_0001);
    wr(`LVIRC_OFS_STATUS, 32'h0000_0001);
    rd(`LVIRC_OFS_STATUS); chk(d & 32'h0000_0001, 32'h0000_0000);
    $display("test power_up done");

    wr(`LVIRC_OFS_MASK, 32'h0000_0000);
    n = irq_cnt;
    lvl <= 2'd1;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    chk(irq_cnt - n, 1);
    rd(`LVIRC_OFS_STATUS); chk(d, 32'h0000_000C);
    lvl <= 2'd2;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    chk(irq_cnt - n, 1);
    lvl <= 2'd0;
    wait_rst(1'b1); chk(ok, 1);
    rd(`LVIRC_OFS_STATUS); chk(d, 32'h0000_0010);
    rd(`LVIRC_OFS_MASK); chk(d, 32'h0000_0001);
    $display("test warn_then_reset done");

    lvl <= 2'd2;
    wait_rst(1'b0); chk(ok, 1);
    // software masks the detector through the stabilisation wait
    wr(`LVIRC_OFS_CTRL, 32'h0000_0080);
    wr(`LVIRC_OFS_LEVEL, 32'h0000_0081);
    rd(`LVIRC_OFS_LEVEL); chk(d, 32'h0000_0081);
    wr(`LVIRC_OFS_MASK, 32'h0000_0000);
    n = irq_cnt;
    lvl <= 2'd1;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    chk(irq_cnt - n, 0);
    lvl <= 2'd0;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    chk(supply_detector_rst, 0);
    // supply recovers before the mask is lifted, else lifting it resets the level
    lvl <= 2'd2;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    wr(`LVIRC_OFS_LEVEL, 32'h0000_0001);
    wr(`LVIRC_OFS_CTRL, 32'h0000_0000);
    wr(`LVIRC_OFS_LEVEL, 32'h0000_0000);
    rd(`LVIRC_OFS_LEVEL); chk(d, 32'h0000_0001);
    $display("test write_enable_mask done");

    // detector off: the external reset is held low at least 10 us
    lvl     <= 2'd0;
    opt_hi  <= 1'b0;
    opt_lo  <= 1'b1;
    hresetn <= 1'b0;
    repeat (100) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(supply_detector_rst, 0);
    n = irq_cnt;
    lvl <= 2'd2;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    lvl <= 2'd1;
    repeat (`LVIRC_DET_DELAY_CYC + 100) @(posedge hclk);
    chk(irq_cnt - n, 0);
    chk(supply_detector_rst, 0);
    $display("test detector_off done");
    summarize();
  end
endmodule
